// ### svw_pkg.sv
// Shared constants for the supervisor, watchdog and serial front end.
package svw_pkg;

   // Eight-bit command codes, most significant bit first on the wire.
   localparam logic [7:0] CMD_SET_WRITE_LATCH   = 8'h06;
   localparam logic [7:0] CMD_SET_FLAG          = 8'h00;
   localparam logic [7:0] CMD_CLEAR_LATCH_FLAG  = 8'h04;
   localparam logic [7:0] CMD_READ_STATUS       = 8'h05;
   localparam logic [7:0] CMD_WRITE_STATUS      = 8'h01;
   localparam logic [7:0] CMD_READ              = 8'h03;
   localparam logic [7:0] CMD_WRITE             = 8'h02;

   // Status byte field positions.
   localparam int ST_LOCK_ENABLE = 7;
   localparam int ST_RESET_FLAG  = 6;
   localparam int ST_WD_SEL_HI   = 5;
   localparam int ST_WD_SEL_LO   = 4;
   localparam int ST_PROT_HI     = 3;
   localparam int ST_PROT_LO     = 2;
   localparam int ST_WRITE_LATCH = 1;
   localparam int ST_WRITE_BUSY  = 0;

   // Factory image of the nonvolatile status bits.
   localparam logic [7:0] NV_RESET_IMAGE = 8'h00;
   localparam logic [1:0] WD_SEL_OFF     = 2'h3;

   // Frame layout: opcode, two address bytes, then data.
   localparam logic [5:0] BYTE_FIRST_DATA = 6'h03;
   localparam logic [5:0] BYTE_IDX_MAX    = 6'h3F;
   localparam logic [5:0] PAGE_BYTES      = 6'h20;
   localparam int         ADDR_W          = 13;
   localparam int         PAGE_W          = 5;

   // Timing, in milliseconds, and the core clock rate.
   localparam longint CORE_CLK_HZ    = 50000000;
   localparam longint SCK_MAX_HZ     = 2000000;
   localparam longint HOLD_MS        = 200;
   localparam longint NV_WRITE_MS    = 5;
   localparam longint WD_PERIOD0_MS  = 1000;
   localparam longint WD_PERIOD1_MS  = 300;
   localparam longint WD_PERIOD2_MS  = 100;

   localparam logic [31:0] HOLD_CYC     = 32'(HOLD_MS * CORE_CLK_HZ / 1000);
   localparam logic [31:0] NV_WRITE_CYC = 32'(NV_WRITE_MS * CORE_CLK_HZ / 1000);
   localparam logic [31:0] WD_CYC0      = 32'(WD_PERIOD0_MS * CORE_CLK_HZ / 1000);
   localparam logic [31:0] WD_CYC1      = 32'(WD_PERIOD1_MS * CORE_CLK_HZ / 1000);
   localparam logic [31:0] WD_CYC2      = 32'(WD_PERIOD2_MS * CORE_CLK_HZ / 1000);

   typedef enum logic [1:0] {
      WR_IDLE,
      WR_PAGE,
      WR_NV
   } svw_wr_state_e;

endpackage : svw_pkg

// ### svw_sync3.sv
// Three-stage pin synchroniser that changes only when stages two and three agree.
`timescale 1ns/10ps
module svw_sync3 #(
   parameter bit RST_VAL = 1'b0
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_async,
   output logic      o_level
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_level <= RST_VAL;
      end else if (s2_q == s3_q) begin
         o_level <= s3_q;
      end
   end

endmodule : svw_sync3

// ### svw_supervisor_front.sv
// Supervisor front end: serial slave, status byte, watchdog and reset hold.
//
// How it works
// RULE_01: Chip select high deselects and floats the serial output.
// RULE_02: Deselected means standby, unless a nonvolatile write is still running.
// RULE_03: Chip select low enables the device in its active state.
// RULE_04: Commands are ignored until a first falling select edge after power-up.
// RULE_05: Every falling edge of the select input restarts the watchdog from zero.
// RULE_06: No falling edge within the timeout asserts the reset output.
// RULE_07: Watchdog fires only when enabled, with select stuck high or low.
// RULE_08: Watchdog interval is one of three presets kept in nonvolatile bits.
// RULE_09: Read data leaves on the push-pull output at falling clock edges.
// RULE_10: Input bits are sampled on rising clock edges, most significant first.
// RULE_11: Serial modes 0,0 and 1,1 work up to the maximum clock rate.
// RULE_12: Open-drain reset output, either polarity, asserted while supply is low.
// RULE_13: Reset stays asserted for the hold interval after supply returns.
// RULE_14: At power-up reset asserts and holds for the hold interval.
// RULE_15: Write-protect pin plus lock bit freeze watchdog and protection bits.
// RULE_16: One write accepts up to one 32-byte page.
// RULE_17: Nonvolatile writes are self-timed and report busy meanwhile.
// RULE_18: Protection covers none, upper quarter, upper half or whole array.
// RULE_19: A volatile flag tells a watchdog reset from a low-supply reset.
// RULE_20: Seven eight-bit commands are decoded as listed in the package.
// RULE_21: Status byte is lock, flag, watchdog select, protect select, latch, busy.
// RULE_22: The write latch clears at power-up and after each completed write.
// RULE_23: Read and write carry a 16-bit address; low 13 bits pick the byte.
// RULE_24: Page write address advances per byte and wraps inside the page.
`timescale 1ns/10ps
module svw_supervisor_front
   import svw_pkg::*;
#(
   parameter bit          RESET_ACTIVE_HIGH = 1'b0,
   parameter logic [31:0] P_HOLD_CYC        = HOLD_CYC,
   parameter logic [31:0] P_NV_WRITE_CYC    = NV_WRITE_CYC,
   parameter logic [31:0] P_WD_CYC0         = WD_CYC0,
   parameter logic [31:0] P_WD_CYC1         = WD_CYC1,
   parameter logic [31:0] P_WD_CYC2         = WD_CYC2
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire logic              i_sck,
   input  wire logic              i_select_and_kick_n,
   input  wire logic              i_si,
   output logic                   o_so_out,
   output logic                   o_so_oe,
   input  wire logic              i_write_protect_n,
   input  wire logic              i_supply_ok,
   output logic                   o_reset_out,
   output logic                   o_reset_oe,
   output logic                   o_active,
   output logic                   o_standby,
   input  wire logic [7:0]        i_nv_image,
   output logic      [7:0]        o_nv_image,
   output logic      [7:0]        o_status,
   output logic      [ADDR_W-1:0] o_mem_raddr,
   input  wire logic [7:0]        i_mem_rdata,
   output logic                   o_mem_we,
   output logic      [ADDR_W-1:0] o_mem_waddr,
   output logic      [7:0]        o_mem_wdata
);

   function automatic logic addr_protected(input logic [ADDR_W-1:0] addr,
                                           input logic [1:0]        sel);
      logic hit;
      hit = 1'b0;
      case (sel)
         2'h0: hit = 1'b0;
         2'h1: hit = (addr[ADDR_W-1:ADDR_W-2] == 2'h3);
         2'h2: hit = addr[ADDR_W-1];
         default: hit = 1'b1;
      endcase
      return hit;
   endfunction : addr_protected

   function automatic logic [31:0] wd_limit(input logic [1:0] sel);
      logic [31:0] lim;
      lim = P_WD_CYC0;
      case (sel)
         2'h0: lim = P_WD_CYC0;
         2'h1: lim = P_WD_CYC1;
         default: lim = P_WD_CYC2;
      endcase
      return lim;
   endfunction : wd_limit

   // ---------------- Link domain, clocked by the serial clock ----------------
   // Select high clears the bit position at once, so a frame cut short
   // leaves no partial byte behind for the next one.
   logic                  link_rst;
   logic [2:0]            bit_cnt_q;
   logic                  fresh_q;
   logic [6:0]            shift_q;
   logic [7:0]            rx_byte;
   logic                  byte_done;
   logic [5:0]            byte_idx_q;
   logic [7:0]            opcode_q;
   logic [15:0]           addr_q;
   logic [ADDR_W-1:0]     rd_addr_q;
   logic [PAGE_W-1:0]     wr_ptr_q;
   logic [7:0]            page_q [PAGE_BYTES];
   logic [7:0]            status_wr_q;
   logic [7:0]            st_s1_q;
   logic [7:0]            st_s2_q;
   logic [6:0]            tx_q;
   logic [7:0]            tx_src;

   assign link_rst  = i_rst | i_select_and_kick_n;
   assign rx_byte   = {shift_q, i_si};
   assign byte_done = (bit_cnt_q == 3'h7);

   always_ff @(posedge i_sck or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt_q <= 3'h0;
         fresh_q   <= 1'b1;
         shift_q   <= 7'h00;
      end else begin
         fresh_q   <= 1'b0;
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q   <= rx_byte[6:0]; // RULE_10
      end
   end

   // Frame contents survive deselection so the core side can act on them.
   always_ff @(posedge i_sck or posedge i_rst) begin
      if (i_rst) begin
         byte_idx_q  <= 6'h00;
         opcode_q    <= 8'h00;
         addr_q      <= 16'h0000;
         rd_addr_q   <= '0;
         wr_ptr_q    <= '0;
         status_wr_q <= 8'h00;
      end else begin
         if (fresh_q) begin
            byte_idx_q <= 6'h00;
         end else if (byte_done && byte_idx_q != BYTE_IDX_MAX) begin
            byte_idx_q <= byte_idx_q + 6'h01;
         end
         if (byte_done && !fresh_q) begin
            if (byte_idx_q == 6'h00) begin
               opcode_q <= rx_byte; // RULE_20
            end else if (byte_idx_q == 6'h01) begin
               addr_q[15:8] <= rx_byte; // RULE_23
               status_wr_q  <= rx_byte;
            end else if (byte_idx_q == 6'h02) begin
               addr_q[7:0] <= rx_byte;
               rd_addr_q   <= {addr_q[ADDR_W-1:8], rx_byte}; // RULE_23
               wr_ptr_q    <= rx_byte[PAGE_W-1:0];
            end else if (opcode_q == CMD_WRITE) begin
               wr_ptr_q <= wr_ptr_q + 5'h01; // RULE_24
            end else if (opcode_q == CMD_READ) begin
               rd_addr_q <= rd_addr_q + 13'h0001;
            end
         end
      end
   end

   always_ff @(posedge i_sck) begin
      if (byte_done && !fresh_q && byte_idx_q >= BYTE_FIRST_DATA && opcode_q == CMD_WRITE) begin
         page_q[wr_ptr_q] <= rx_byte; // RULE_24
      end
   end

   always_ff @(posedge i_sck or posedge i_rst) begin
      if (i_rst) begin
         st_s1_q <= 8'h00;
         st_s2_q <= 8'h00;
      end else begin
         st_s1_q <= o_status;
         st_s2_q <= st_s1_q;
      end
   end

   always_comb begin
      tx_src = 8'h00;
      if (opcode_q == CMD_READ_STATUS && byte_idx_q != 6'h00) begin
         tx_src = st_s2_q;
      end else if (opcode_q == CMD_READ && byte_idx_q >= BYTE_FIRST_DATA) begin
         tx_src = i_mem_rdata;
      end
   end

   // The output changes on falling edges only, which serves both idle
   // levels of the serial clock.
   always_ff @(negedge i_sck or posedge link_rst) begin
      if (link_rst) begin
         o_so_oe  <= 1'b0; // RULE_01
         o_so_out <= 1'b0;
         tx_q     <= 7'h00;
      end else begin
         o_so_oe <= 1'b1;
         if (bit_cnt_q == 3'h0 && !fresh_q) begin
            o_so_out <= tx_src[7]; // RULE_09 RULE_11
            tx_q     <= tx_src[6:0];
         end else begin
            o_so_out <= tx_q[6]; // RULE_09
            tx_q     <= {tx_q[5:0], 1'b0};
         end
      end
   end

   always_ff @(posedge i_sck or posedge i_rst) begin
      if (i_rst) begin
         o_mem_raddr <= '0;
      end else begin
         o_mem_raddr <= (byte_done && byte_idx_q == 6'h02) ?
                        {addr_q[ADDR_W-1:8], rx_byte} :
                        ((byte_done && byte_idx_q >= BYTE_FIRST_DATA && opcode_q == CMD_READ) ?
                         rd_addr_q + 13'h0001 : rd_addr_q);
      end
   end

   // ---------------- Core domain ----------------
   logic                  cs_lvl;
   logic                  sup_lvl;
   logic                  cs_prev_q;
   logic                  cs_fall;
   logic                  cs_rise;
   logic                  armed_q;
   logic                  frame_go;
   logic                  nv_loaded_q;
   logic                  lock_q;
   logic                  flag_q;
   logic [1:0]            wd_sel_q;
   logic [1:0]            prot_q;
   logic                  wel_q;
   logic                  frozen;
   logic                  busy;
   svw_wr_state_e         st_q;
   logic [5:0]            left_q;
   logic [PAGE_W-1:0]     ptr_q;
   logic [7:0]            page_base_q;
   logic [31:0]           nv_cnt_q;
   logic                  wr_done;
   logic                  go_write;
   logic                  go_status;
   logic [5:0]            data_cnt;
   logic [ADDR_W-1:0]     wr_addr;
   logic                  rst_act_q;
   logic [31:0]           hold_cnt_q;
   logic [31:0]           wd_cnt_q;
   logic                  wd_on;
   logic                  wd_fire;

   svw_sync3 #(.RST_VAL(1'b1)) u_cs_sync (
      .i_clk   (i_core_clk),
      .i_rst   (i_rst),
      .i_async (i_select_and_kick_n),
      .o_level (cs_lvl)
   );

   svw_sync3 #(.RST_VAL(1'b0)) u_supply_sync (
      .i_clk   (i_core_clk),
      .i_rst   (i_rst),
      .i_async (i_supply_ok),
      .o_level (sup_lvl)
   );

   assign cs_fall  = cs_prev_q & ~cs_lvl;
   assign cs_rise  = ~cs_prev_q & cs_lvl;
   // The link registers are stable here because the serial clock is idle
   // while deselected.
   assign frame_go = cs_rise & armed_q & (byte_idx_q != 6'h00); // RULE_04
   assign busy     = (st_q != WR_IDLE); // RULE_17
   assign frozen   = lock_q & ~i_write_protect_n; // RULE_15
   assign data_cnt = (byte_idx_q - BYTE_FIRST_DATA > PAGE_BYTES) ?
                     PAGE_BYTES : byte_idx_q - BYTE_FIRST_DATA; // RULE_16
   assign go_write  = frame_go & ~busy & wel_q & (opcode_q == CMD_WRITE) &
                      (byte_idx_q > BYTE_FIRST_DATA);
   assign go_status = frame_go & ~busy & wel_q & (opcode_q == CMD_WRITE_STATUS) &
                      (byte_idx_q >= 6'h02);
   assign wr_done   = (st_q == WR_NV) && (nv_cnt_q == P_NV_WRITE_CYC - 32'h1);
   assign wr_addr   = {page_base_q, ptr_q};
   assign wd_on     = (wd_sel_q != WD_SEL_OFF);
   assign wd_fire   = wd_on & ~rst_act_q & ~cs_fall &
                      (wd_cnt_q == wd_limit(wd_sel_q) - 32'h1); // RULE_06 RULE_07

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cs_prev_q <= 1'b1;
         armed_q   <= 1'b0;
         o_active  <= 1'b0;
         o_standby <= 1'b1;
      end else begin
         cs_prev_q <= cs_lvl;
         if (cs_fall) begin
            armed_q <= 1'b1; // RULE_04
         end
         o_active  <= ~cs_lvl; // RULE_03
         o_standby <= cs_lvl & ~busy; // RULE_02
      end
   end

   // Nonvolatile bits are restored from the retained image once after reset.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         nv_loaded_q <= 1'b0;
         lock_q      <= NV_RESET_IMAGE[ST_LOCK_ENABLE];
         wd_sel_q    <= NV_RESET_IMAGE[ST_WD_SEL_HI:ST_WD_SEL_LO];
         prot_q      <= NV_RESET_IMAGE[ST_PROT_HI:ST_PROT_LO];
      end else if (!nv_loaded_q) begin
         nv_loaded_q <= 1'b1;
         lock_q      <= i_nv_image[ST_LOCK_ENABLE];
         wd_sel_q    <= i_nv_image[ST_WD_SEL_HI:ST_WD_SEL_LO]; // RULE_08
         prot_q      <= i_nv_image[ST_PROT_HI:ST_PROT_LO];
      end else if (go_status && !frozen) begin
         lock_q   <= status_wr_q[ST_LOCK_ENABLE]; // RULE_15
         wd_sel_q <= status_wr_q[ST_WD_SEL_HI:ST_WD_SEL_LO];
         prot_q   <= status_wr_q[ST_PROT_HI:ST_PROT_LO]; // RULE_18
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wel_q <= 1'b0; // RULE_22
      end else if (wr_done || (frame_go && opcode_q == CMD_CLEAR_LATCH_FLAG)) begin
         wel_q <= 1'b0; // RULE_22
      end else if (frame_go && !busy && opcode_q == CMD_SET_WRITE_LATCH) begin
         wel_q <= 1'b1;
      end
   end

   // A watchdog expiry sets the flag even in the cycle software clears it.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_q <= 1'b0;
      end else if (wd_fire) begin
         flag_q <= 1'b1; // RULE_19
      end else if (!sup_lvl) begin
         flag_q <= 1'b0; // RULE_19
      end else if (frame_go && opcode_q == CMD_SET_FLAG) begin
         flag_q <= 1'b1;
      end else if (frame_go && opcode_q == CMD_CLEAR_LATCH_FLAG) begin
         flag_q <= 1'b0;
      end else if (go_status) begin
         flag_q <= status_wr_q[ST_RESET_FLAG];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_status   <= 8'h00;
         o_nv_image <= NV_RESET_IMAGE;
      end else begin
         o_status   <= {lock_q, flag_q, wd_sel_q, prot_q, wel_q, busy}; // RULE_21
         o_nv_image <= {lock_q, 1'b0, wd_sel_q, prot_q, 2'h0};
      end
   end

   // Page commit: bytes go out one per cycle, then the self-timed cycle runs.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q        <= WR_IDLE;
         left_q      <= 6'h00;
         ptr_q       <= '0;
         page_base_q <= 8'h00;
         nv_cnt_q    <= 32'h0;
      end else begin
         case (st_q)
            WR_IDLE: begin
               nv_cnt_q <= 32'h0;
               if (go_write) begin
                  st_q        <= WR_PAGE;
                  left_q      <= data_cnt; // RULE_16
                  ptr_q       <= addr_q[PAGE_W-1:0];
                  page_base_q <= addr_q[ADDR_W-1:PAGE_W];
               end else if (go_status) begin
                  st_q <= WR_NV; // RULE_17
               end
            end
            WR_PAGE: begin
               if (left_q == 6'h00) begin
                  st_q <= WR_NV;
               end else begin
                  left_q <= left_q - 6'h01;
                  ptr_q  <= ptr_q + 5'h01; // RULE_24
               end
            end
            WR_NV: begin
               nv_cnt_q <= nv_cnt_q + 32'h1;
               if (wr_done) begin
                  st_q <= WR_IDLE; // RULE_17
               end
            end
            default: st_q <= WR_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mem_we    <= 1'b0;
         o_mem_waddr <= '0;
         o_mem_wdata <= 8'h00;
      end else begin
         o_mem_we    <= (st_q == WR_PAGE) && (left_q != 6'h00) &&
                        !addr_protected(wr_addr, prot_q); // RULE_18
         o_mem_waddr <= wr_addr;
         o_mem_wdata <= page_q[ptr_q];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wd_cnt_q <= 32'h0;
      end else if (cs_fall || !wd_on || rst_act_q || wd_fire) begin
         wd_cnt_q <= 32'h0; // RULE_05
      end else begin
         wd_cnt_q <= wd_cnt_q + 32'h1;
      end
   end

   // Any low supply or watchdog expiry restarts the full hold interval.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rst_act_q  <= 1'b1; // RULE_14
         hold_cnt_q <= 32'h0;
      end else if (!sup_lvl || wd_fire) begin
         rst_act_q  <= 1'b1; // RULE_12 RULE_06
         hold_cnt_q <= 32'h0;
      end else if (rst_act_q) begin
         if (hold_cnt_q == P_HOLD_CYC - 32'h1) begin
            rst_act_q <= 1'b0; // RULE_13 RULE_14
         end else begin
            hold_cnt_q <= hold_cnt_q + 32'h1;
         end
      end
   end

   // Open drain can only pull low, so the enable follows the low level.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reset_oe  <= ~RESET_ACTIVE_HIGH;
         o_reset_out <= 1'b0;
      end else begin
         o_reset_oe  <= RESET_ACTIVE_HIGH ? ~rst_act_q : rst_act_q; // RULE_12
         o_reset_out <= 1'b0;
      end
   end

endmodule : svw_supervisor_front

// ### svw_front_checker_asserts.sv
// Port-level assertions for the supervisor front end.
`timescale 1ns/10ps
module svw_front_checker
   import svw_pkg::*;
#(
   parameter logic [31:0] P_HOLD_CYC = HOLD_CYC,
   parameter logic [31:0] P_WD_CYC0  = WD_CYC0,
   parameter logic [31:0] P_WD_CYC1  = WD_CYC1,
   parameter logic [31:0] P_WD_CYC2  = WD_CYC2
) (
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic       i_sck,
   input wire logic       i_select_and_kick_n,
   input wire logic       i_supply_ok,
   input wire logic       o_so_out,
   input wire logic       o_so_oe,
   input wire logic       o_reset_out,
   input wire logic       o_reset_oe,
   input wire logic       o_active,
   input wire logic       o_standby,
   input wire logic [7:0] o_status,
   input wire logic       o_mem_we
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // Counters follow the raw pins, so they lead the design by its synchroniser delay.
   logic [31:0] sup_q;
   logic [31:0] kick_q;
   logic [31:0] lim;
   logic        sel_q;
   assign lim = (o_status[5:4] == 2'h0) ? P_WD_CYC0 : (o_status[5:4] == 2'h1) ? P_WD_CYC1 : P_WD_CYC2;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sup_q  <= 32'h0;
         kick_q <= 32'h0;
         sel_q  <= 1'h1;
      end else begin
         sel_q  <= i_select_and_kick_n;
         sup_q  <= i_supply_ok ? sup_q + 32'h1 : 32'h0;
         kick_q <= (!i_supply_ok || (sel_q && !i_select_and_kick_n)) ? 32'h0 : kick_q + 32'h1;
      end
   end
   chk_so_float: assert property (i_select_and_kick_n |-> !o_so_oe)
      else $error("serial output driven while deselected");
   chk_power_state: assert property (o_active |-> !o_standby)
      else $error("active and standby together");
   chk_select_active: assert property (!i_select_and_kick_n [*6] |-> o_active)
      else $error("selected device not active");
   // Guarded against the power-up hold so that only a plain missed kick is judged.
   chk_wd_expiry: assert property (kick_q == lim + 32'h8 && o_status[5:4] != WD_SEL_OFF
      && sup_q > kick_q + P_HOLD_CYC + 32'h8 |-> o_reset_oe) else $error("watchdog did not fire");
   chk_od_low: assert property (!o_reset_out) else $error("reset pin driven high");
   chk_supply_rst: assert property (!i_supply_ok [*7] |-> o_reset_oe)
      else $error("low supply without reset");
   chk_hold_time: assert property ($fell(o_reset_oe) |-> sup_q >= P_HOLD_CYC)
      else $error("reset released before hold interval");
   chk_busy_len: assert property ($rose(o_status[ST_WRITE_BUSY]) |-> o_status[ST_WRITE_BUSY] [*8])
      else $error("write busy too short");
   chk_we_busy: assert property (o_mem_we |-> ##[0:1] o_status[ST_WRITE_BUSY])
      else $error("array write without busy");
   chk_wel_clear: assert property ($fell(o_status[ST_WRITE_BUSY]) |-> !o_status[ST_WRITE_LATCH])
      else $error("write latch kept after write");
   chk_flag_supply: assert property (!i_supply_ok [*6] |-> ##1 !o_status[ST_RESET_FLAG])
      else $error("flag kept through low supply");
   chk_so_edge: assert property ($changed(o_so_out) && o_so_oe |-> !i_sck)
      else $error("serial output moved on rising clock");
   cov_write: cover property (o_mem_we);
   cov_reset: cover property ($rose(o_reset_oe));
   cov_read: cover property (o_so_oe && !i_sck);
endmodule : svw_front_checker
bind svw_supervisor_front svw_front_checker #(.P_HOLD_CYC(P_HOLD_CYC), .P_WD_CYC0(P_WD_CYC0),
   .P_WD_CYC1(P_WD_CYC1), .P_WD_CYC2(P_WD_CYC2)) u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_sck(i_sck), .i_select_and_kick_n(i_select_and_kick_n), .i_supply_ok(i_supply_ok),
   .o_so_out(o_so_out), .o_so_oe(o_so_oe), .o_reset_out(o_reset_out), .o_reset_oe(o_reset_oe),
   .o_active(o_active), .o_standby(o_standby), .o_status(o_status), .o_mem_we(o_mem_we));

// ### svw_host_model.sv
// Host microcontroller model: serial bus master in either clock mode.
`timescale 1ns/10ps
module svw_host_model (
   output logic      o_sck,
   output logic      o_sel_n,
   output logic      o_si,
   input  wire logic i_so
);
   logic cpol = 1'b0;
   initial begin
      o_sck   = 1'b0;
      o_sel_n = 1'b1;
      o_si    = 1'b0;
   end
   // The clock idles at the mode's level and stands still between frames.
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      o_sck = cpol;
      #3 o_sel_n = 1'b0;
      #24;
      foreach (tx[i]) begin
         for (int k = 7; k >= 0; k--) begin
            o_sck = 1'b0;
            o_si = tx[i][k];
            #24 o_sck = 1'b1;
            b[k] = i_so;
            #24;
         end
         rx.push_back(b);
      end
      o_sck = cpol;
      #24 o_sel_n = 1'b1;
      o_si = ~o_si;
      #200;
   endtask : frame
endmodule : svw_host_model

// ### testbench.sv
// Self-checking bench with host model, array model and write scoreboard.
`timescale 1ns/10ps
module testbench;
   import svw_pkg::*;
   logic clk = 1'b0, rst = 1'b1, sup = 1'b1, wp_n = 1'b1;
   logic sck, sel_n, si, so_out, so_oe, rst_out, rst_oe, act, stby, we;
   logic [ADDR_W-1:0] raddr, waddr;
   logic [7:0] wdata, rdata, nv_out, status, d0, d1, nv_keep = NV_RESET_IMAGE;
   logic [7:0] mem [8192];
   logic [7:0] rx[$];
   logic [20:0] exp_q[$];
   logic [31:0] seed = 32'h38;
   int bad_count = 0, check_count = 0;
   wire logic so_wire = so_oe ? so_out : 1'bz;
   always #10 clk = ~clk;
   assign rdata = mem[raddr];
   svw_supervisor_front #(.P_HOLD_CYC(32'h32), .P_NV_WRITE_CYC(32'h14), .P_WD_CYC0(32'h190),
      .P_WD_CYC1(32'h12C), .P_WD_CYC2(32'hC8)) u_svw_supervisor_front (.i_core_clk(clk),
      .i_rst(rst), .i_sck(sck), .i_select_and_kick_n(sel_n), .i_si(si), .o_so_out(so_out),
      .o_so_oe(so_oe), .i_write_protect_n(wp_n), .i_supply_ok(sup), .o_reset_out(rst_out),
      .o_reset_oe(rst_oe), .o_active(act), .o_standby(stby), .i_nv_image(nv_keep),
      .o_nv_image(nv_out), .o_status(status), .o_mem_raddr(raddr), .i_mem_rdata(rdata),
      .o_mem_we(we), .o_mem_waddr(waddr), .o_mem_wdata(wdata));
   svw_host_model u_svw_host_model (.o_sck(sck), .o_sel_n(sel_n), .o_si(si), .i_so(so_wire));
   task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic xf(input logic [7:0] tx[$]);
      u_svw_host_model.frame(tx, rx);
   endtask : xf
   task automatic rdsr(input logic [7:0] e);
      xf({CMD_READ_STATUS, 8'h00});
      chk("status", {13'h0, e}, {13'h0, rx[1]});
   endtask : rdsr
   task automatic write_status_cmd(input logic [7:0] v);
      xf({CMD_SET_WRITE_LATCH});
      xf({CMD_WRITE_STATUS, v});
      cyc(30);
   endtask : write_status_cmd
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd
   task automatic results();
      if (bad_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   // Retained image comes back on the next reset, as an external nonvolatile store would.
   always @(posedge clk) if (!rst) nv_keep <= nv_out;
   // A write with nothing expected meets an all-ones value and is reported unless it writes FF to the last address.
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
         chk("mem_write", exp_q.size() ? exp_q.pop_front() : 21'h1FFFFF, {waddr, wdata});
      end
   end
   initial begin
      #400000;
      bad_count++;
      results();
   end
   initial begin
      cyc(2);
      rst = 1'b0;
      cyc(60);
      for (int m = 0; m < 2; m++) begin
         u_svw_host_model.cpol = m[0];
         d0 = rnd();
         d1 = rnd();
         xf({CMD_SET_WRITE_LATCH});
         rdsr(8'h02);
         exp_q.push_back({13'h001F, d0});
         exp_q.push_back({13'h0000, d1});
         xf({CMD_WRITE, 8'h00, 8'h1F, d0, d1});
         chk("busy", 21'h1, {20'h0, status[ST_WRITE_BUSY]});
         cyc(30);
         rdsr(8'h00);
         xf({CMD_READ, 8'h00, 8'h1F, 8'h00});
         chk("read", {13'h0, d0}, {13'h0, rx[3]});
      end
      xf({CMD_SET_WRITE_LATCH});
      xf({CMD_SET_FLAG});
      rdsr(8'h42);
      xf({CMD_CLEAR_LATCH_FLAG});
      rdsr(8'h00);
      write_status_cmd(8'hA0);
      wp_n = 1'b0;
      write_status_cmd(8'h30);
      rdsr(8'hA0);
      cyc(1);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      cyc(60);
      rdsr(8'hA0);
      cyc(170);
      chk("wd_reset", 21'h1, {20'h0, rst_oe});
      cyc(60);
      rdsr(8'hE0);
      cyc(1);
      wp_n = 1'b1;
      write_status_cmd(8'h3C);
      rdsr(8'h3C);
      xf({CMD_SET_WRITE_LATCH});
      xf({CMD_WRITE, 8'h00, 8'h05, 8'h5A});
      cyc(450);
      chk("wd_off", 21'h0, {20'h0, rst_oe});
      xf({CMD_SET_FLAG});
      cyc(1);
      sup = 1'b0;
      cyc(10);
      chk("supply_low", 21'h1, {20'h0, rst_oe});
      sup = 1'b1;
      cyc(30);
      chk("hold", 21'h1, {20'h0, rst_oe});
      cyc(40);
      chk("release", 21'h0, {20'h0, rst_oe});
      rdsr(8'h3C);
      results();
   end
endmodule : testbench
